// ==== design/timer_ch34_params.svh ====
// register offsets, field positions and reset values of the channel 3/4 mode block
`ifndef TIMER_CH34_PARAMS_SVH
`define TIMER_CH34_PARAMS_SVH
`define MODE_CONFIG_OFFSET     12'h01c
`define MODE_CONFIG_RESET      32'h0000_0000
`define CH34_CTRL_OFFSET       12'h040
`define CH34_STATUS_OFFSET     12'h044
`define ADDR_WIDTH             12
`define C4_CLR_BIT             15
`define C4_MODE_HI             14
`define C4_MODE_LO             12
`define C4_PRE_BIT             11
`define C4_FAST_BIT            10
`define C4_SEL_HI              9
`define C4_SEL_LO              8
`define C3_CLR_BIT             7
`define C3_MODE_HI             6
`define C3_MODE_LO             4
`define C3_PRE_BIT             3
`define C3_FAST_BIT            2
`define C3_SEL_HI              1
`define C3_SEL_LO              0
`define CFG_FIELD_MASK         32'h0000_fcfc
`define RESP_OKAY              2'b00
`define RESP_SLVERR            2'b10
`endif

// ==== design/timer_ch34_pkg.sv ====
// types shared by the channel 3/4 mode block
package timer_ch34_pkg;
   typedef enum logic [1:0] {
      SEL_OUTPUT   = 2'b00,
      SEL_OWN_IN   = 2'b01,
      SEL_OTHER_IN = 2'b10,
      SEL_TRIGGER  = 2'b11
   } dir_sel_e;

   typedef enum logic [1:0] {
      SRC_NONE    = 2'b00,
      SRC_INPUT_3 = 2'b01,
      SRC_INPUT_4 = 2'b10,
      SRC_TRIGGER = 2'b11
   } capture_src_e;

   typedef enum logic [1:0] {
      WR_IDLE = 2'b00,
      WR_RESP = 2'b01
   } wr_state_e;
endpackage : timer_ch34_pkg

// ==== design/timer_ch34_mode_config.sv ====
// channel 3/4 mode configuration register with axi4-lite slave and capture source routing
//
// Contract
// - the mode register sits at byte offset 0x1c and resets to all zeros.
// - channel 4 select 00 is output, 01 input four, 10 input three, 11 internal trigger.
// - channel 3 select 00 is output, 01 input three, 10 input four, 11 internal trigger.
// - code 11 gives a capture input only while an internal trigger is selected by the slave mode field.
// - the channel 4 select field is written only while channel 4 is disabled.
// - the channel 3 select field is written only while channel 3 is disabled.
// - channel 4 output fields are clear enable 15, mode 14:12, preload 11, fast 10, all zero at reset.
// - channel 3 output fields are clear enable 7, mode 6:4, preload 3, fast 2, all zero at reset.
// - in input mode bits 15:12 are the channel 4 filter and 11:10 its prescaler.
// - in input mode bits 7:4 are the channel 3 filter and 3:2 its prescaler.
//
// The AXI4-Lite interface to the registers was decided locally.
`include "timer_ch34_params.svh"
`timescale 1ns/1ps
`default_nettype none
module timer_ch34_mode_config (
   input  wire logic                         aclk,
   input  wire logic                         aresetn,
   input  wire logic [11:0]                  s_axi_awaddr,
   input  wire logic                         s_axi_awvalid,
   output var  logic                         s_axi_awready,
   input  wire logic [31:0]                  s_axi_wdata,
   input  wire logic [3:0]                   s_axi_wstrb,
   input  wire logic                         s_axi_wvalid,
   output var  logic                         s_axi_wready,
   output var  logic [1:0]                   s_axi_bresp,
   output var  logic                         s_axi_bvalid,
   input  wire logic                         s_axi_bready,
   input  wire logic [11:0]                  s_axi_araddr,
   input  wire logic                         s_axi_arvalid,
   output var  logic                         s_axi_arready,
   output var  logic [31:0]                  s_axi_rdata,
   output var  logic [1:0]                   s_axi_rresp,
   output var  logic                         s_axi_rvalid,
   input  wire logic                         s_axi_rready,
   input  wire logic                         trigger_select_internal,
   output var  logic                         chan_three_is_output,
   output var  logic                         chan_four_is_output,
   output var  timer_ch34_pkg::capture_src_e chan_three_capture_src,
   output var  timer_ch34_pkg::capture_src_e chan_four_capture_src,
   output var  logic [15:0]                  mode_fields
);
   import timer_ch34_pkg::*;

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   function automatic capture_src_e route(input logic [1:0] sel, input logic own_is_four,
                                          input logic trig_ok);
      capture_src_e src;
      src = SRC_NONE;
      case (sel)
         SEL_OWN_IN:   src = own_is_four ? SRC_INPUT_4 : SRC_INPUT_3;
         SEL_OTHER_IN: src = own_is_four ? SRC_INPUT_3 : SRC_INPUT_4;
         SEL_TRIGGER:  src = trig_ok ? SRC_TRIGGER : SRC_NONE;
         default:      src = SRC_NONE;
      endcase
      return src;
   endfunction : route

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] st);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (st[b]) begin
            res[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return res;
   endfunction : merge

   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   logic [15:0] mode_cfg;
   logic [15:0] next_mode_cfg;
   logic [1:0]  chan_enables;           // bit0 channel 3 enable, bit1 channel 4 enable
   logic [1:0]  next_chan_enables;
   logic [1:0]  refused;                // sticky: a select write was held back
   logic [1:0]  next_refused;

   // handshake flags, all registered
   logic        awready_q;
   logic        wready_q;
   logic        arready_q;
   logic        bvalid_q;

   // write channel capture, either order
   logic        aw_held;
   logic        next_aw_held;
   logic [11:0] aw_addr;
   logic [11:0] next_aw_addr;
   logic        w_held;
   logic        next_w_held;
   logic [31:0] w_data;
   logic [31:0] next_w_data;
   logic [3:0]  w_strb;
   logic [3:0]  next_w_strb;
   wr_state_e   wr_state;
   wr_state_e   next_wr_state;
   logic [1:0]  next_bresp;

   logic        rvalid;
   logic        next_rvalid;
   logic [31:0] rdata;
   logic [31:0] next_rdata;
   logic [1:0]  rresp;
   logic [1:0]  next_rresp;

   logic [1:0]  bresp;
   logic        three_out;
   logic        four_out;
   logic        next_three_out;
   logic        next_four_out;
   capture_src_e src3;
   capture_src_e src4;
   capture_src_e next_src3;
   capture_src_e next_src4;

   logic        do_write;
   logic [31:0] wd;

   // ----------------------------------------------------------------
   // write path
   // ----------------------------------------------------------------
   always_comb begin
      next_aw_held      = aw_held;
      next_aw_addr      = aw_addr;
      next_w_held       = w_held;
      next_w_data       = w_data;
      next_w_strb       = w_strb;
      next_wr_state     = wr_state;
      next_bresp        = bresp;
      next_mode_cfg     = mode_cfg;
      next_chan_enables = chan_enables;
      next_refused      = refused;
      do_write          = 1'b0;
      wd                = 32'h0000_0000;
      // take a channel only while its ready is shown, or the master would repeat the transfer
      if (s_axi_awvalid && awready_q) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      case (wr_state)
         WR_IDLE: begin
            if (aw_held && w_held) begin
               do_write      = 1'b1;
               next_aw_held  = 1'b0;
               next_w_held   = 1'b0;
               next_wr_state = WR_RESP;
               next_bresp    = `RESP_OKAY;
               if (aw_addr[11:2] == `MODE_CONFIG_OFFSET >> 2) begin
                  wd = merge({16'h0000, mode_cfg}, w_data, w_strb);
                  // upper half is reserved and kept at zero
                  next_mode_cfg = wd[15:0] & 16'(`CFG_FIELD_MASK);
                  if (!chan_enables[0]) begin
                     next_mode_cfg[`C3_SEL_HI:`C3_SEL_LO] = wd[`C3_SEL_HI:`C3_SEL_LO];
                  end else if (wd[`C3_SEL_HI:`C3_SEL_LO] != mode_cfg[`C3_SEL_HI:`C3_SEL_LO]) begin
                     next_mode_cfg[`C3_SEL_HI:`C3_SEL_LO] = mode_cfg[`C3_SEL_HI:`C3_SEL_LO];
                     next_refused[0] = 1'b1;
                  end else begin
                     next_mode_cfg[`C3_SEL_HI:`C3_SEL_LO] = mode_cfg[`C3_SEL_HI:`C3_SEL_LO];
                  end
                  if (!chan_enables[1]) begin
                     next_mode_cfg[`C4_SEL_HI:`C4_SEL_LO] = wd[`C4_SEL_HI:`C4_SEL_LO];
                  end else if (wd[`C4_SEL_HI:`C4_SEL_LO] != mode_cfg[`C4_SEL_HI:`C4_SEL_LO]) begin
                     next_mode_cfg[`C4_SEL_HI:`C4_SEL_LO] = mode_cfg[`C4_SEL_HI:`C4_SEL_LO];
                     next_refused[1] = 1'b1;
                  end else begin
                     next_mode_cfg[`C4_SEL_HI:`C4_SEL_LO] = mode_cfg[`C4_SEL_HI:`C4_SEL_LO];
                  end
               end else if (aw_addr[11:2] == `CH34_CTRL_OFFSET >> 2) begin
                  if (w_strb[0]) begin
                     next_chan_enables = w_data[1:0];
                  end
               end else if (aw_addr[11:2] == `CH34_STATUS_OFFSET >> 2) begin
                  // write one to clear
                  if (w_strb[0]) begin
                     next_refused = refused & ~w_data[1:0];
                  end
               end else begin
                  next_bresp = `RESP_SLVERR;
               end
            end
         end
         WR_RESP: begin
            if (s_axi_bready) begin
               next_wr_state = WR_IDLE;
            end
         end
         default: next_wr_state = WR_IDLE;
      endcase
   end

   // ----------------------------------------------------------------
   // read path, one cycle after address accept
   // ----------------------------------------------------------------
   always_comb begin
      next_rvalid = rvalid;
      next_rdata  = rdata;
      next_rresp  = rresp;
      if (rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (arready_q && s_axi_arvalid) begin
         next_rvalid = 1'b1;
         next_rresp  = `RESP_OKAY;
         if (s_axi_araddr[11:2] == `MODE_CONFIG_OFFSET >> 2) begin
            next_rdata = {16'h0000, mode_cfg};
         end else if (s_axi_araddr[11:2] == `CH34_CTRL_OFFSET >> 2) begin
            next_rdata = {30'h0, chan_enables};
         end else if (s_axi_araddr[11:2] == `CH34_STATUS_OFFSET >> 2) begin
            next_rdata = {28'h0, refused, four_out, three_out};
         end else begin
            next_rdata = 32'h0000_0000;
            next_rresp = `RESP_SLVERR;
         end
      end
   end

   // ----------------------------------------------------------------
   // channel routing outputs
   // ----------------------------------------------------------------
   always_comb begin
      next_three_out = (next_mode_cfg[`C3_SEL_HI:`C3_SEL_LO] == SEL_OUTPUT);
      next_four_out  = (next_mode_cfg[`C4_SEL_HI:`C4_SEL_LO] == SEL_OUTPUT);
      next_src3 = route(next_mode_cfg[`C3_SEL_HI:`C3_SEL_LO], 1'b0, trigger_select_internal);
      next_src4 = route(next_mode_cfg[`C4_SEL_HI:`C4_SEL_LO], 1'b1, trigger_select_internal);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_cfg     <= 16'(`MODE_CONFIG_RESET);
         chan_enables <= 2'b00;
         refused      <= 2'b00;
         aw_held      <= 1'b0;
         aw_addr      <= 12'h000;
         w_held       <= 1'b0;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
         wr_state     <= WR_IDLE;
         bresp        <= `RESP_OKAY;
         rvalid       <= 1'b0;
         rdata        <= 32'h0000_0000;
         rresp        <= `RESP_OKAY;
         three_out    <= 1'b1;
         four_out     <= 1'b1;
         src3         <= SRC_NONE;
         src4         <= SRC_NONE;
      end else begin
         mode_cfg     <= next_mode_cfg;
         chan_enables <= next_chan_enables;
         refused      <= next_refused;
         aw_held      <= next_aw_held;
         aw_addr      <= next_aw_addr;
         w_held       <= next_w_held;
         w_data       <= next_w_data;
         w_strb       <= next_w_strb;
         wr_state     <= next_wr_state;
         bresp        <= next_bresp;
         rvalid       <= next_rvalid;
         rdata        <= next_rdata;
         rresp        <= next_rresp;
         three_out    <= next_three_out;
         four_out     <= next_four_out;
         src3         <= next_src3;
         src4         <= next_src4;
      end
   end

   // ready flags are registered state in disguise: high only while idle and not yet holding
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         arready_q <= 1'b0;
         bvalid_q  <= 1'b0;
      end else begin
         awready_q <= !next_aw_held && next_wr_state == WR_IDLE && !(s_axi_awvalid && awready_q);
         wready_q  <= !next_w_held && next_wr_state == WR_IDLE && !(s_axi_wvalid && wready_q);
         arready_q <= !next_rvalid && !(s_axi_arvalid && arready_q);
         bvalid_q  <= (next_wr_state == WR_RESP);
      end
   end

   assign s_axi_awready          = awready_q;
   assign s_axi_wready           = wready_q;
   assign s_axi_arready          = arready_q;
   assign s_axi_bvalid           = bvalid_q;
   assign s_axi_bresp            = bresp;
   assign s_axi_rvalid           = rvalid;
   assign s_axi_rdata            = rdata;
   assign s_axi_rresp            = rresp;
   assign chan_three_is_output   = three_out;
   assign chan_four_is_output    = four_out;
   assign chan_three_capture_src = src3;
   assign chan_four_capture_src  = src4;
   assign mode_fields            = mode_cfg;
endmodule : timer_ch34_mode_config
`default_nettype wire

// ==== verif/timer_ch34_mode_config_monitor.sv ====
// port checker for the channel 3/4 mode block
`timescale 1ns/1ps
`default_nettype none
module timer_ch34_mode_config_monitor (
   input wire logic                         aclk,
   input wire logic                         aresetn,
   input wire logic [11:0]                  s_axi_awaddr,
   input wire logic                         s_axi_awvalid,
   input wire logic                         s_axi_awready,
   input wire logic [31:0]                  s_axi_wdata,
   input wire logic [3:0]                   s_axi_wstrb,
   input wire logic                         s_axi_wvalid,
   input wire logic                         s_axi_wready,
   input wire logic [1:0]                   s_axi_bresp,
   input wire logic                         s_axi_bvalid,
   input wire logic                         s_axi_bready,
   input wire logic [11:0]                  s_axi_araddr,
   input wire logic                         s_axi_arvalid,
   input wire logic                         s_axi_arready,
   input wire logic [31:0]                  s_axi_rdata,
   input wire logic [1:0]                   s_axi_rresp,
   input wire logic                         s_axi_rvalid,
   input wire logic                         s_axi_rready,
   input wire logic                         trigger_select_internal,
   input wire logic                         chan_three_is_output,
   input wire logic                         chan_four_is_output,
   input wire timer_ch34_pkg::capture_src_e chan_three_capture_src,
   input wire timer_ch34_pkg::capture_src_e chan_four_capture_src,
   input wire logic [15:0]                  mode_fields
);
   import timer_ch34_pkg::*;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   function automatic capture_src_e src_of(input logic [1:0] sel, input logic trig, input logic four);
      case (sel)
         2'b00: return SRC_NONE;
         2'b01: return four ? SRC_INPUT_4 : SRC_INPUT_3;
         2'b10: return four ? SRC_INPUT_3 : SRC_INPUT_4;
         default: return trig ? SRC_TRIGGER : SRC_NONE;
      endcase
   endfunction : src_of

   // ------------------------------------------
   // assertions
   // ------------------------------------------
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   // capture sources lag trigger_select_internal by a cycle, so compare once settled
   sequence sel_settled;
      $stable(mode_fields[9:8]) && $stable(mode_fields[1:0]) && $stable(trigger_select_internal);
   endsequence
   property p_reset;
      disable iff (1'b0) !aresetn |=> mode_fields == 16'h0000 && chan_three_is_output && chan_four_is_output
         && chan_three_capture_src == SRC_NONE && chan_four_capture_src == SRC_NONE
         && !s_axi_bvalid && !s_axi_rvalid;
   endproperty

   AST_RESET_CLEARS: assert property (p_reset) else $error("reset did not clear the mode state");
   AST_OUT3: assert property (sel_settled |-> chan_three_is_output == (mode_fields[1:0] == 2'b00))
      else $error("channel 3 direction wrong");
   AST_OUT4: assert property (sel_settled |-> chan_four_is_output == (mode_fields[9:8] == 2'b00))
      else $error("channel 4 direction wrong");
   AST_SRC3: assert property (sel_settled |->
      chan_three_capture_src == src_of(mode_fields[1:0], trigger_select_internal, 1'b0))
      else $error("channel 3 capture source wrong");
   AST_SRC4: assert property (sel_settled |->
      chan_four_capture_src == src_of(mode_fields[9:8], trigger_select_internal, 1'b1))
      else $error("channel 4 capture source wrong");
   AST_WR_RESP: assert property (wr_taken |-> ##[1:4] s_axi_bvalid) else $error("write response late");
   AST_RD_RESP: assert property (rd_taken |-> ##[1:2] s_axi_rvalid) else $error("read response late");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   AST_RD_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
      else $error("upper half not zero");
endmodule : timer_ch34_mode_config_monitor

bind timer_ch34_mode_config timer_ch34_mode_config_monitor mon (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .trigger_select_internal(trigger_select_internal), .chan_three_is_output(chan_three_is_output),
   .chan_four_is_output(chan_four_is_output), .chan_three_capture_src(chan_three_capture_src),
   .chan_four_capture_src(chan_four_capture_src), .mode_fields(mode_fields)
);
`default_nettype wire

// ==== verif/timer_ch34_mode_config_tb.sv ====
// register-level testbench for the channel 3/4 mode block
`timescale 1ns/1ps
`default_nettype none
module timer_ch34_mode_config_tb;
   import timer_ch34_pkg::*;
   logic               aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic               trigger_select_internal, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic               s_axi_rvalid, chan_three_is_output, chan_four_is_output;
   logic [11:0]        s_axi_awaddr, s_axi_araddr;
   logic [31:0]        s_axi_wdata, s_axi_rdata;
   logic [3:0]         s_axi_wstrb;
   logic [1:0]         s_axi_bresp, s_axi_rresp;
   logic [15:0]        mode_fields;
   capture_src_e       chan_three_capture_src, chan_four_capture_src;
   int                 n_fail = 0;
   int                 check_count = 0;

   timer_ch34_mode_config dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .trigger_select_internal(trigger_select_internal), .chan_three_is_output(chan_three_is_output),
      .chan_four_is_output(chan_four_is_output), .chan_three_capture_src(chan_three_capture_src),
      .chan_four_capture_src(chan_four_capture_src), .mode_fields(mode_fields));

   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   task automatic finish_test();
      if (n_fail == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   function automatic capture_src_e exp_src(input logic [1:0] sel, input logic trig, input logic four);
      case (sel)
         2'b00: return SRC_NONE;
         2'b01: return four ? SRC_INPUT_4 : SRC_INPUT_3;
         2'b10: return four ? SRC_INPUT_3 : SRC_INPUT_4;
         default: return trig ? SRC_TRIGGER : SRC_NONE;
      endcase
   endfunction : exp_src

   // response ready is raised one edge after acceptance, on the same edge the response appears, so no response waits
   task automatic wr_chk(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (s_axi_awready && !aw_ok) aw_ok = 1'b1;
         if (s_axi_wready && !w_ok) w_ok = 1'b1;
         s_axi_awvalid <= !aw_ok;
         s_axi_wvalid <= !w_ok;
      end
      @(posedge aclk);
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      check(32'(s_axi_bresp), 32'(er));
      s_axi_bready <= 1'b0;
   endtask : wr_chk

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      @(posedge aclk);
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      check(s_axi_rdata, ed);
      check(32'(s_axi_rresp), 32'(er));
      s_axi_rready <= 1'b0;
   endtask : rd_chk

   initial begin
      repeat (20000) @(posedge aclk);
      n_fail++;
      finish_test();
   end

   // ------------------------------------------
   // tests
   // ------------------------------------------
   initial begin
      logic [15:0] f;
      logic [1:0]  sl;
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {trigger_select_internal, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd_chk(12'h01c, 32'h0000_0000, 2'b00);
      for (int t = 0; t < 2; t++) begin
         for (int s = 0; s < 4; s++) begin
            sl = 2'(s);
            f = ((t == 0 ? 16'h5c5c : 16'ha4a4) & 16'hfcfc) | {6'h00, ~sl, 6'h00, sl};
            trigger_select_internal <= t[0];
            wr_chk(12'h01c, {16'h0000, f}, 4'hf, 2'b00);
            rd_chk(12'h01c, {16'h0000, f}, 2'b00);
            repeat (2) @(posedge aclk);
            check(32'(mode_fields), 32'(f));
            check(32'(chan_three_is_output), 32'(sl == 2'b00));
            check(32'(chan_four_is_output), 32'(sl == 2'b11));
            check(32'(chan_three_capture_src), 32'(exp_src(sl, t[0], 1'b0)));
            check(32'(chan_four_capture_src), 32'(exp_src(~sl, t[0], 1'b1)));
         end
      end
      wr_chk(12'h01c, 32'h0000_0201, 4'hf, 2'b00);
      wr_chk(12'h040, 32'h0000_0001, 4'hf, 2'b00);
      wr_chk(12'h01c, 32'h0000_ffff, 4'hf, 2'b00);
      rd_chk(12'h01c, 32'h0000_fffd, 2'b00);
      wr_chk(12'h040, 32'h0000_0003, 4'hf, 2'b00);
      wr_chk(12'h01c, 32'h0000_0000, 4'hf, 2'b00);
      rd_chk(12'h01c, 32'h0000_0301, 2'b00);
      wr_chk(12'h040, 32'h0000_0002, 4'hf, 2'b00);
      wr_chk(12'h01c, 32'h0000_0002, 4'hf, 2'b00);
      rd_chk(12'h01c, 32'h0000_0302, 2'b00);
      rd_chk(12'h044, 32'h0000_000c, 2'b00);
      wr_chk(12'h044, 32'h0000_0003, 4'hf, 2'b00);
      rd_chk(12'h044, 32'h0000_0000, 2'b00);
      wr_chk(12'h040, 32'h0000_0000, 4'hf, 2'b00);
      wr_chk(12'h01c, 32'h0000_0000, 4'hf, 2'b00);
      wr_chk(12'h01c, 32'h0000_fcfc, 4'h1, 2'b00);
      rd_chk(12'h01c, 32'h0000_00fc, 2'b00);
      wr_chk(12'h100, 32'hffff_ffff, 4'hf, 2'b10);
      rd_chk(12'h01c, 32'h0000_00fc, 2'b00);
      rd_chk(12'h100, 32'h0000_0000, 2'b10);
      aresetn <= 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd_chk(12'h01c, 32'h0000_0000, 2'b00);
      finish_test();
   end
endmodule : timer_ch34_mode_config_tb
`default_nettype wire
